// ===== logic/ppc_cfg.svh
/*
 * Constants of the port pad configuration block: register byte offsets,
 * reset values, implemented-bit masks and field positions.
 * Assumes inclusion by bare name from every file that needs them.
 */
`ifndef PPC_CFG_SVH
`define PPC_CFG_SVH

// Register byte offsets on the APB window.
`define PPC_OFS_PAD_CONFIG   8'h00
`define PPC_OFS_PB_PULLUP    8'h04
`define PPC_OFS_OPEN_DRAIN   8'h08
`define PPC_OFS_SLEW         8'h0C
`define PPC_OFS_ANALOG_LOW   8'h10
`define PPC_OFS_ANALOG_HIGH  8'h14
`define PPC_OFS_INT_CTRL_TWO 8'h18

// Reset values.
`define PPC_RST_PAD_CONFIG   8'h00
`define PPC_RST_PB_PULLUP    8'hFF
`define PPC_RST_OPEN_DRAIN   8'h00
`define PPC_RST_SLEW         8'h00
`define PPC_RST_ANALOG       8'hFF
`define PPC_RST_INT_CTRL_TWO 8'h80

// Implemented bits of the pad configuration register per package.
`define PPC_PADCFG_MASK_64   8'hF1
`define PPC_PADCFG_MASK_40   8'hC1
`define PPC_PADCFG_MASK_28   8'h01

// Implemented bits of the slew register per package.
`define PPC_SLEW_MASK_64     8'h7F
`define PPC_SLEW_MASK_40     8'h1F
`define PPC_SLEW_MASK_28     8'h03

// Field positions.
`define PPC_BIT_PD_PU        7
`define PPC_BIT_PE_PU        6
`define PPC_BIT_PF_PU        5
`define PPC_BIT_PG_PU        4
`define PPC_BIT_CMP_SRC      0
`define PPC_BIT_PB_OFF_N     7

`endif

// ===== logic/ppc_pkg.sv
/*
 * Types of the port pad configuration block.
 * Assumes ppc_cfg.svh supplies the numeric constants.
 */
package ppc_pkg;

   // Package variant that decides which bits exist.
   typedef enum logic [1:0] {
      PPC_PINS_28,
      PPC_PINS_40,
      PPC_PINS_64
   } ppc_pins_t;

endpackage : ppc_pkg

// ===== logic/ppc_od_pad.sv
/*
 * One peripheral output pad with a selectable open-drain mode.
 * Assumes the peripheral's value and enable are synchronous to pclk.
 */
`timescale 1ns/1ps

module ppc_od_pad
   import ppc_pkg::*;
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic periph_out,
   input  wire logic periph_oe,
   input  wire logic od_en,
   output logic      pad_out,
   output logic      pad_oe
);

   // In open-drain mode only a low level is driven; a high releases the pin.
   // (R14) drive low only
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pad_out <= 1'b0;
         pad_oe  <= 1'b0;
      end
      else if (od_en)
      begin
         pad_out <= 1'b0;
         pad_oe  <= periph_oe & ~periph_out;
      end
      else
      begin
         pad_out <= periph_out;
         pad_oe  <= periph_oe;
      end
   end

endmodule : ppc_od_pad

// ===== logic/ppc_top.sv
/*
 * Port pad configuration: APB register file for pull-ups, open-drain,
 * slew rate, analog select and measurement compare source, plus the
 * pad-control outputs derived from them.
 * Assumes an APB master on pclk and pad inputs synchronous to pclk.
 */
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "ppc_cfg.svh"

////////////////////////////////////////////////////////////////////////
// Behaviour
// (R01) One pull-up enable per port; port B global, D..G in pad config.
// (R02) Ports D..G: enable 1 follows pin latch, 0 disables all.
// (R03) D/E enables absent on 28-pin; F/G absent on 40-pin.
// (R04) Pad config bit 0 picks external pin as compare data source.
// (R05) Port B pin pull-up when bit set, global off_n low, pin input.
// (R06) Open-drain option only on serial, SPI and capture/compare pins.
// (R07) Open-drain bits: 7 SPI, 6..2 units 5..1, 1 serial2, 0 serial1.
// (R08) Analog select bit set makes pin analog, clear makes it digital.
// (R09) Slew bit 1 selects reduced rate per port, bit 0 port A.
// (R10) Missing port slew bits and bit 7 read as zero.
// (R11) Slew register resets to 0, the standard rate.
// (R12) Port B pull-up off for outputs; all off after reset.
// (R13) Direction 1 is input, released; 0 drives latch value.
// (R14) Open-drain outputs drive only low, release for a high.
module ppc_top
   import ppc_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [1:0]  package_pins,
   input  wire logic [7:0]  port_b_latch,
   input  wire logic [7:0]  port_b_dir,
   input  wire logic [7:0]  port_d_latch,
   input  wire logic [7:0]  port_e_latch,
   input  wire logic [7:0]  port_f_latch,
   input  wire logic [7:0]  port_g_latch,
   input  wire logic        measure_data_input_pin,
   input  wire logic        internal_cmp_out,
   input  wire logic [7:0]  periph_out,
   input  wire logic [7:0]  periph_oe,
   output logic      [7:0]  periph_pad_out,
   output logic      [7:0]  periph_pad_oe,
   output logic      [7:0]  port_b_pad_out,
   output logic      [7:0]  port_b_pad_oe,
   output logic      [7:0]  port_b_pullup_q,
   output logic      [7:0]  port_d_pullup_q,
   output logic      [7:0]  port_e_pullup_q,
   output logic      [7:0]  port_f_pullup_q,
   output logic      [7:0]  port_g_pullup_q,
   output logic      [6:0]  port_slow_slew_q,
   output logic      [7:0]  analog_select_low_q,
   output logic      [7:0]  analog_select_high_q,
   output logic             measure_compare_data_q
);

   ////////////////////////////////////////////////////////////////////
   // Registers and decode.

   ppc_pins_t  pins_q;
   logic [7:0] pad_config_q;
   logic [7:0] port_b_pullup_enables_q;
   logic [7:0] open_drain_control_q;
   logic [7:0] slew_rate_control_q;
   logic [7:0] int_ctrl_two_q;
   logic [7:0] padcfg_mask;
   logic [7:0] slew_mask;
   logic       wr_en;
   logic       rd_ok;
   logic [7:0] rd_byte;
   logic       port_b_global_pullup_off_n;

   // Zero-wait slave: every access completes in its first access cycle.
   assign pready = 1'b1;
   assign wr_en  = psel & penable & pwrite;
   assign port_b_global_pullup_off_n = int_ctrl_two_q[`PPC_BIT_PB_OFF_N];

   // The package variant is a strap sampled once per cycle after reset.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pins_q <= PPC_PINS_64;
      else
      begin
         case (package_pins)
            2'h0:    pins_q <= PPC_PINS_28;
            2'h1:    pins_q <= PPC_PINS_40;
            default: pins_q <= PPC_PINS_64;
         endcase
      end
   end

   // Implemented-bit masks follow the package variant.
   // (R03) absent enables
   // (R10) absent slew bits
   always_comb
   begin
      case (pins_q)
         PPC_PINS_28:
         begin
            padcfg_mask = `PPC_PADCFG_MASK_28;
            slew_mask   = `PPC_SLEW_MASK_28;
         end
         PPC_PINS_40:
         begin
            padcfg_mask = `PPC_PADCFG_MASK_40;
            slew_mask   = `PPC_SLEW_MASK_40;
         end
         default:
         begin
            padcfg_mask = `PPC_PADCFG_MASK_64;
            slew_mask   = `PPC_SLEW_MASK_64;
         end
      endcase
   end

   // Pad configuration: pull-up enables of D..G and compare source.
   // (R01) per-port enables
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pad_config_q <= `PPC_RST_PAD_CONFIG;
      else if (wr_en && paddr == `PPC_OFS_PAD_CONFIG)
         pad_config_q <= pwdata[7:0] & padcfg_mask;
      else
         pad_config_q <= pad_config_q & padcfg_mask;
   end

   // Port B per-pin pull-up bits and its global control.
   // (R12) pull-ups off at reset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         port_b_pullup_enables_q <= `PPC_RST_PB_PULLUP;
         int_ctrl_two_q          <= `PPC_RST_INT_CTRL_TWO;
      end
      else
      begin
         if (wr_en && paddr == `PPC_OFS_PB_PULLUP)
            port_b_pullup_enables_q <= pwdata[7:0];
         if (wr_en && paddr == `PPC_OFS_INT_CTRL_TWO)
            int_ctrl_two_q <= pwdata[7:0];
      end
   end

   // Open-drain selection for the eight peripheral outputs.
   // (R07) open-drain bit map
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         open_drain_control_q <= `PPC_RST_OPEN_DRAIN;
      else if (wr_en && paddr == `PPC_OFS_OPEN_DRAIN)
         open_drain_control_q <= pwdata[7:0];
   end

   // Slew control resets to the standard rate.
   // (R11) standard rate at reset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         slew_rate_control_q <= `PPC_RST_SLEW;
      else if (wr_en && paddr == `PPC_OFS_SLEW)
         slew_rate_control_q <= pwdata[7:0] & slew_mask;
      else
         slew_rate_control_q <= slew_rate_control_q & slew_mask;
   end

   // Analog select registers drive the pin mode outputs directly.
   // (R08) analog or digital
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         analog_select_low_q  <= `PPC_RST_ANALOG;
         analog_select_high_q <= `PPC_RST_ANALOG;
      end
      else
      begin
         if (wr_en && paddr == `PPC_OFS_ANALOG_LOW)
            analog_select_low_q <= pwdata[7:0];
         if (wr_en && paddr == `PPC_OFS_ANALOG_HIGH)
            analog_select_high_q <= pwdata[7:0];
      end
   end

   // Read mux; unmapped offsets answer with an error and zero data.
   always_comb
   begin
      rd_ok   = 1'b1;
      rd_byte = 8'h00;
      case (paddr)
         `PPC_OFS_PAD_CONFIG:   rd_byte = pad_config_q;
         `PPC_OFS_PB_PULLUP:    rd_byte = port_b_pullup_enables_q;
         `PPC_OFS_OPEN_DRAIN:   rd_byte = open_drain_control_q;
         `PPC_OFS_SLEW:         rd_byte = slew_rate_control_q;
         `PPC_OFS_ANALOG_LOW:   rd_byte = analog_select_low_q;
         `PPC_OFS_ANALOG_HIGH:  rd_byte = analog_select_high_q;
         `PPC_OFS_INT_CTRL_TWO: rd_byte = int_ctrl_two_q;
         default:               rd_ok   = 1'b0;
      endcase
      prdata  = {24'h000000, rd_byte};
      pslverr = psel & penable & ~rd_ok;
   end

   ////////////////////////////////////////////////////////////////////
   // Pad control outputs.

   // Port B pull-up: pin bit set, global control low and pin an input.
   // (R05) port B pin pull-up
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         port_b_pullup_q <= 8'h00;
      else if (port_b_global_pullup_off_n)
         port_b_pullup_q <= 8'h00;
      else
         port_b_pullup_q <= port_b_pullup_enables_q & port_b_dir;
   end

   // Port B pad drive follows direction and latch.
   // (R13) direction drives pad
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         port_b_pad_out <= 8'h00;
         port_b_pad_oe  <= 8'h00;
      end
      else
      begin
         port_b_pad_out <= port_b_latch;
         port_b_pad_oe  <= ~port_b_dir;
      end
   end

   // Ports D..G: each pin's pull-up follows its latch under the enable.
   // (R02) latch-driven pull-ups
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         port_d_pullup_q <= 8'h00;
         port_e_pullup_q <= 8'h00;
         port_f_pullup_q <= 8'h00;
         port_g_pullup_q <= 8'h00;
      end
      else
      begin
         port_d_pullup_q <= port_d_latch
            & {8{pad_config_q[`PPC_BIT_PD_PU]}};
         port_e_pullup_q <= port_e_latch
            & {8{pad_config_q[`PPC_BIT_PE_PU]}};
         port_f_pullup_q <= port_f_latch
            & {8{pad_config_q[`PPC_BIT_PF_PU]}};
         port_g_pullup_q <= port_g_latch
            & {8{pad_config_q[`PPC_BIT_PG_PU]}};
      end
   end

   // Slew selection per port, A in bit 0 through G in bit 6.
   // (R09) reduced slew select
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         port_slow_slew_q <= 7'h00;
      else
         port_slow_slew_q <= slew_rate_control_q[6:0] & slew_mask[6:0];
   end

   // Compare data comes from the external pin or the internal comparator.
   // (R04) compare source select
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         measure_compare_data_q <= 1'b0;
      else if (pad_config_q[`PPC_BIT_CMP_SRC])
         measure_compare_data_q <= measure_data_input_pin;
      else
         measure_compare_data_q <= internal_cmp_out;
   end

   // One open-drain capable pad per peripheral output, none elsewhere.
   // (R06) open-drain only here
   for (genvar i = 0; i < 8; i++)
   begin : g_od
      ppc_od_pad u_pad (
         .pclk       (pclk),
         .presetn    (presetn),
         .periph_out (periph_out[i]),
         .periph_oe  (periph_oe[i]),
         .od_en      (open_drain_control_q[i]),
         .pad_out    (periph_pad_out[i]),
         .pad_oe     (periph_pad_oe[i])
      );
   end

   ////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_pb_output_off: assert property ( // (R12)
      (port_b_pullup_q & ~$past(port_b_dir)) == 8'h00)
      else $error("port B pull-up on an output pin");

   chk_pb_global_off: assert property ( // (R05)
      $past(port_b_global_pullup_off_n) |-> port_b_pullup_q == 8'h00)
      else $error("port B pull-up while globally off");

   chk_pd_port_off: assert property ( // (R02)
      !$past(pad_config_q[`PPC_BIT_PD_PU]) |-> port_d_pullup_q == 8'h00)
      else $error("port D pull-up while disabled");

   chk_small_pkg_pu: assert property ( // (R03)
      ##1 pins_q == PPC_PINS_28 && $stable(pins_q)
      |-> pad_config_q[7:4] == 4'h0)
      else $error("absent pull-up enable holds a one");

   chk_od_no_high: assert property ( // (R14)
      (periph_pad_oe & periph_pad_out & $past(open_drain_control_q))
      == 8'h00)
      else $error("open-drain pad drives high");

   chk_slew_top_zero: assert property ( // (R10)
      psel && paddr == `PPC_OFS_SLEW |-> prdata[7] == 1'b0)
      else $error("slew bit 7 reads one");

   chk_cmp_source: assert property ( // (R04)
      $past(pad_config_q[`PPC_BIT_CMP_SRC])
      |-> measure_compare_data_q == $past(measure_data_input_pin))
      else $error("compare data not from external pin");

   chk_od_write: assert property ( // (R07)
      wr_en && paddr == `PPC_OFS_OPEN_DRAIN
      |=> open_drain_control_q == $past(pwdata[7:0]))
      else $error("open-drain write lost");

   chk_dir_drive: assert property ( // (R13)
      $past(presetn) |-> port_b_pad_oe == ~$past(port_b_dir))
      else $error("port B drive does not follow direction");

   chk_analog_write: assert property ( // (R08)
      wr_en && paddr == `PPC_OFS_ANALOG_LOW
      |=> ##1 analog_select_low_q == $past(pwdata[7:0], 2))
      else $error("analog select write lost");

endmodule : ppc_top

// ===== dv/ppc_board.sv
/*
 * Board model beside the peripheral pads: an external pull-up on each
 * peripheral line, as open-drain use needs.
 * Assumes pad value and enable come straight from the block.
 */
`timescale 1ns/1ps

module ppc_board
(
   input  wire logic [7:0] periph_pad_out,
   input  wire logic [7:0] periph_pad_oe,
   output logic      [7:0] periph_line
);
   // A driven line follows the pad; a released line is pulled high.
   // external pull-up
   assign periph_line = ~periph_pad_oe | periph_pad_out;
endmodule : ppc_board

// ===== dv/testbench.sv
/*
 * Self-checking bench: APB register tests, package straps, pull-up,
 * open-drain, slew, analog and compare-source outputs.
 * Assumes ppc_top and ppc_board are compiled before it.
 */
`timescale 1ns/1ps
`include "ppc_cfg.svh"

module testbench;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr, pb_lat, pb_dir, pd_lat, pe_lat, pf_lat, pg_lat;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0]  package_pins;
   logic        meas_pin, int_cmp, err;
   logic [7:0]  p_out, p_oe, pp_out, pp_oe, pbo, pboe, line;
   logic [7:0]  pbu, pdu, peu, pfu, pgu, anl, anh;
   logic [6:0]  slew;
   logic        cmpd;
   int          failures, samples_checked;
   logic [7:0]  offs[7] = '{`PPC_OFS_PAD_CONFIG, `PPC_OFS_PB_PULLUP,
      `PPC_OFS_OPEN_DRAIN, `PPC_OFS_SLEW, `PPC_OFS_ANALOG_LOW,
      `PPC_OFS_ANALOG_HIGH, `PPC_OFS_INT_CTRL_TWO};
   logic [7:0]  rstv[7] = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF,
      8'h80};
   logic [7:0]  pm[3] = '{8'h01, 8'hC1, 8'hF1};
   logic [7:0]  sm[3] = '{8'h03, 8'h1F, 8'h7F};

   ppc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .package_pins(package_pins), .port_b_latch(pb_lat),
      .port_b_dir(pb_dir), .port_d_latch(pd_lat), .port_e_latch(pe_lat),
      .port_f_latch(pf_lat), .port_g_latch(pg_lat),
      .measure_data_input_pin(meas_pin), .internal_cmp_out(int_cmp),
      .periph_out(p_out), .periph_oe(p_oe), .periph_pad_out(pp_out),
      .periph_pad_oe(pp_oe), .port_b_pad_out(pbo), .port_b_pad_oe(pboe),
      .port_b_pullup_q(pbu), .port_d_pullup_q(pdu),
      .port_e_pullup_q(peu), .port_f_pullup_q(pfu),
      .port_g_pullup_q(pgu), .port_slow_slew_q(slew),
      .analog_select_low_q(anl), .analog_select_high_q(anh),
      .measure_compare_data_q(cmpd));

   ppc_board u_board (.periph_pad_out(pp_out), .periph_pad_oe(pp_oe),
      .periph_line(line));

   ////////////////////////////////////////
   // Prints the verdict and stops the run.
   task end_sim;
      if (failures == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_sim

   // Compares one value and reports a mismatch.
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         $display("wrong value %s exp %h got %h", n, e, g);
         failures++;
      end
   endtask : chk

   // One APB transfer; holds the request until pready is seen.
   task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Reads one register and checks data and error response.
   task rchk(input logic [7:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      chk("rdata", {24'h000000, e}, rd);
      chk("slverr", 32'h0, {31'h0, err});
   endtask : rchk

   // Lets registered pad outputs follow their inputs.
   task settle;
      repeat (2) @(posedge pclk);
   endtask : settle

   // Resets the block with a given package strap.
   task rst(input logic [1:0] p);
      presetn      <= 1'b0;
      package_pins <= p;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
   endtask : rst

   // Free-running bus clock.
   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   // Cuts a hung run short.
   initial
   begin
      repeat (20000) @(posedge pclk);
      failures++;
      end_sim();
   end

   // Main test sequence.
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata} <= '0;
      {meas_pin, int_cmp} <= 2'h1;
      {pb_lat, pb_dir, pd_lat, pe_lat} <= 32'h96FF3CC3;
      {pf_lat, pg_lat, p_out, p_oe} <= 32'h5AA555FF;
      failures = 0;
      samples_checked = 0;
      for (int p = 0; p < 3; p++)
      begin
         rst(p[1:0]);
         for (int i = 0; i < 7; i++) rchk(offs[i], rstv[i]);
         chk("pb_pu", 8'h00, pbu);
         apb(1'b1, `PPC_OFS_PAD_CONFIG, 8'hFF);
         rchk(`PPC_OFS_PAD_CONFIG, pm[p]);
         apb(1'b1, `PPC_OFS_SLEW, 8'hFF);
         rchk(`PPC_OFS_SLEW, sm[p]);
         settle();
         chk("pd_pu", pm[p][7] ? pd_lat : 8'h00, pdu);
         chk("pe_pu", pm[p][6] ? pe_lat : 8'h00, peu);
         chk("pf_pu", pm[p][5] ? pf_lat : 8'h00, pfu);
         chk("pg_pu", pm[p][4] ? pg_lat : 8'h00, pgu);
         chk("slew", sm[p][6:0], slew);
      end
      apb(1'b1, `PPC_OFS_PAD_CONFIG, 8'h00);
      settle();
      chk("pd_off", 8'h00, pdu);
      chk("cmp_int", 1'b1, cmpd);
      apb(1'b1, `PPC_OFS_PAD_CONFIG, 8'h01);
      settle();
      chk("cmp_ext", 1'b0, cmpd);
      apb(1'b0, 8'h1C, 8'h00);
      chk("unmapped", 32'h1, {31'h0, err});
      apb(1'b1, `PPC_OFS_INT_CTRL_TWO, 8'h00);
      apb(1'b1, `PPC_OFS_PB_PULLUP, 8'hA5);
      pb_dir <= 8'hF0;
      settle();
      chk("pb_pu_in", 8'hA0, pbu);
      chk("pb_oe", 8'h0F, pboe);
      chk("pb_out", pb_lat, pbo);
      apb(1'b1, `PPC_OFS_INT_CTRL_TWO, 8'h80);
      settle();
      chk("pb_pu_off", 8'h00, pbu);
      apb(1'b1, `PPC_OFS_OPEN_DRAIN, 8'h00);
      settle();
      chk("pp_out", 8'h55, pp_out);
      chk("pp_oe", 8'hFF, pp_oe);
      for (int i = 0; i < 8; i++)
      begin
         apb(1'b1, `PPC_OFS_OPEN_DRAIN, 8'h01 << i);
         settle();
         chk("od_oe", 8'hFF ^ ((8'h01 << i) & 8'h55), pp_oe);
         chk("od_out", 8'h55 & ~(8'h01 << i), pp_out);
         chk("od_line", 8'h55, line);
      end
      apb(1'b1, `PPC_OFS_ANALOG_LOW, 8'h5A);
      apb(1'b1, `PPC_OFS_ANALOG_HIGH, 8'h00);
      rchk(`PPC_OFS_ANALOG_LOW, 8'h5A);
      settle();
      chk("an_lo", 8'h5A, anl);
      chk("an_hi", 8'h00, anh);
      end_sim();
   end
endmodule : testbench
